//--- core/lcdcd_pkg.sv
// Purpose: constants shared by the lcd command decoder
// Assumes: avalon-mm register window, 32-bit data, byte addresses
// Notes:   command codes, register offsets and reset values live here
package lcdcd_pkg;
    // ======================================================
    // register byte offsets
    localparam logic [3:0] OFF_CMD    = 4'h0; // write: command byte; read: status byte
    localparam logic [3:0] OFF_DATA   = 4'h4; // write/read display data
    localparam logic [3:0] OFF_STATE  = 4'h8; // read: control state snapshot
    localparam logic [3:0] OFF_STATE2 = 4'hC; // read: addresses and volume
    // ======================================================
    // command codes
    localparam logic [7:0] CMD_VOL_MODE = 8'h81;
    localparam logic [7:0] CMD_IND_OFF  = 8'hAC;
    localparam logic [7:0] CMD_IND_ON   = 8'hAD;
    localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
    localparam logic [7:0] CMD_DISP_ON  = 8'hAF;
    localparam logic [7:0] CMD_SEG_NORM = 8'hA0;
    localparam logic [7:0] CMD_SEG_REV  = 8'hA1;
    localparam logic [7:0] CMD_BIAS6    = 8'hA2;
    localparam logic [7:0] CMD_BIAS5    = 8'hA3;
    localparam logic [7:0] CMD_ALL_NORM = 8'hA4;
    localparam logic [7:0] CMD_ALL_ON   = 8'hA5;
    localparam logic [7:0] CMD_INV_NORM = 8'hA6;
    localparam logic [7:0] CMD_INV_REV  = 8'hA7;
    localparam logic [7:0] CMD_RMW      = 8'hE0;
    localparam logic [7:0] CMD_RESET    = 8'hE2;
    localparam logic [7:0] CMD_NOP      = 8'hE3;
    localparam logic [7:0] CMD_END      = 8'hEE;
    // ======================================================
    // reset values
    localparam logic [5:0] RST_VOLUME   = 6'h20;
    localparam logic [2:0] RST_RATIO    = 3'h0;
    localparam logic [6:0] COL_MAX      = 7'h5F; // last column, 95
    // reset-in-progress flag length in cycles after the reset command
    localparam logic [1:0] RST_BUSY_CYC = 2'h2;
    // ======================================================
    // decoder mode
    typedef enum logic [1:0] {
        LCDCD_NORMAL  = 2'b00,
        LCDCD_VOLWAIT = 2'b01,
        LCDCD_INDWAIT = 2'b10
    } lcdcd_mode_t;
    // power-save state
    typedef enum logic [1:0] {
        LCDCD_RUN     = 2'b00,
        LCDCD_SLEEP   = 2'b01,
        LCDCD_STANDBY = 2'b10
    } lcdcd_pwr_t;
endpackage

//--- core/lcd_command_decoder.sv
// Purpose: command decoder of a dot-matrix lcd controller, behind avalon-mm
// Assumes: single 125 MHz clock; display ram is a 9x96 byte array in flops
// Notes:   one wait state per access; every output comes from a flop
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - six-bit volume selects one of 64 levels
// - volume register load ends volume mode
// - volume mode accepts only volume byte
// - indicator on then only indicator register byte
// - indicator off is a single-byte command
// - indicator register low two bits decode mode
// - only indicator commands and the reset command change indicator state
// - all-on while display off enters power save
// - indicator off sleep, on standby
// - power save keeps data and modes
// - sleep halts oscillator, supply, all drivers
// - standby halts supply, duty drive; oscillator runs
// - reset command in standby goes sleep
// - blanking output low during power save
// - F0-FF enter test; reset/nop exit
// - display on/off and start line decode
// - page address set is 1011 plus page
// - column address from two nibble bytes
// - status read gives four flags, low zero
// - data select high accesses display ram
// - read-modify-write: write increments, read holds
// - segment direction normal or reverse
// - A2 bias 1/6, A3 bias 1/5
// - C0/C8 scan direction, low bits ignored
// - 00101 plus three power enables
// - 00100 plus three-bit divider ratio
// - reset command reinitialises control state
module lcdcd_decoder (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // avalon-mm slave
    input  wire logic [3:0]           address,
    input  wire logic                 read,
    input  wire logic                 write,
    input  wire logic [31:0]          writedata,
    input  wire logic [3:0]           byteenable,
    output logic [31:0]               readdata,
    output logic                      waitrequest,
    // panel control outputs
    output logic                      blank_out_n,
    output logic [1:0]                indicator_drive_out,
    output logic [5:0]                lcd_drive_level,
    output logic                      oscEnable,
    output logic                      driversEnable,
    output logic                      segmentReverse,
    output logic [2:0]                powerEnables,
    output logic [2:0]                divider_ratio,
    output logic                      biasFifth,
    output logic                      comReverse,
    output logic                      testMode
);
    import lcdcd_pkg::*;

    // ======================================================
    // state
    logic [7:0]  dispRam_r [0:8][0:95];
    logic        ack_r, ack_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    lcdcd_mode_t mode_r, mode_nxt;
    lcdcd_pwr_t  pwr_r, pwr_nxt;
    logic        dispOn_r, dispOn_nxt;
    logic        allOn_r, allOn_nxt;
    logic        invert_r, invert_nxt;
    logic [5:0]  startLine_r, startLine_nxt;
    logic [3:0]  page_r, page_nxt;
    logic [6:0]  col_r, col_nxt;
    logic [6:0]  rmwCol_r, rmwCol_nxt;
    logic        rmw_r, rmw_nxt;
    logic        segRev_r, segRev_nxt;
    logic        bias_r, bias_nxt;
    logic        comRev_r, comRev_nxt;
    logic [2:0]  pwrEn_r, pwrEn_nxt;
    logic [2:0]  ratio_r, ratio_nxt;
    logic [5:0]  volume_r, volume_nxt;
    logic [1:0]  indMode_r, indMode_nxt;
    logic        test_r, test_nxt;
    logic [1:0]  rstBusy_r, rstBusy_nxt;
    logic        ramWe;
    logic [3:0]  ramPage;
    logic [6:0]  ramCol;

    // column increment wraps at the last column
    function automatic logic [6:0] colInc(input logic [6:0] c);
        colInc = (c >= COL_MAX) ? 7'h00 : 7'(c + 7'h01);
    endfunction

    // page beyond 8 is clamped to 8 so the index stays in range
    function automatic logic [3:0] pageIdx(input logic [3:0] p);
        pageIdx = (p > 4'h8) ? 4'h8 : p;
    endfunction

    // ======================================================
    // command and bus decode
    logic        cmdWr, dataWr, cmdRd, dataRd;
    logic [7:0]  cb;
    always_comb begin
        cmdWr  = write && !ack_r && address == OFF_CMD && byteenable[0];
        dataWr = write && !ack_r && address == OFF_DATA && byteenable[0];
        cmdRd  = read && !ack_r && address == OFF_CMD;
        dataRd = read && !ack_r && address == OFF_DATA;
        cb     = writedata[7:0];
    end

    // next state of the decoder
    always_comb begin
        ack_nxt       = (read || write) && !ack_r;
        rdata_nxt     = rdata_r;
        mode_nxt      = mode_r;
        pwr_nxt       = pwr_r;
        dispOn_nxt    = dispOn_r;
        allOn_nxt     = allOn_r;
        invert_nxt    = invert_r;
        startLine_nxt = startLine_r;
        page_nxt      = page_r;
        col_nxt       = col_r;
        rmwCol_nxt    = rmwCol_r;
        rmw_nxt       = rmw_r;
        segRev_nxt    = segRev_r;
        bias_nxt      = bias_r;
        comRev_nxt    = comRev_r;
        pwrEn_nxt     = pwrEn_r;
        ratio_nxt     = ratio_r;
        volume_nxt    = volume_r;
        indMode_nxt   = indMode_r;
        test_nxt      = test_r;
        rstBusy_nxt   = (rstBusy_r != 2'h0) ? 2'(rstBusy_r - 2'h1) : 2'h0;
        ramWe         = 1'b0;
        ramPage       = pageIdx(page_r);
        ramCol        = col_r;

        if (cmdWr) begin
            case (mode_r)
                LCDCD_VOLWAIT: begin
                    // only the register byte can follow the mode byte
                    volume_nxt = cb[5:0];
                    mode_nxt   = LCDCD_NORMAL;
                end
                LCDCD_INDWAIT: begin
                    indMode_nxt = cb[1:0];
                    mode_nxt    = LCDCD_NORMAL;
                end
                default: begin
                    // test mode swallows everything except its exits
                    if (test_r && cb == CMD_NOP) begin
                        test_nxt = 1'b0;
                    end
                    if (cb == CMD_RESET) begin
                        startLine_nxt = 6'h00;
                        page_nxt      = 4'h0;
                        col_nxt       = 7'h00;
                        comRev_nxt    = 1'b0;
                        ratio_nxt     = RST_RATIO;
                        volume_nxt    = RST_VOLUME;
                        indMode_nxt   = 2'h0;
                        rmw_nxt       = 1'b0;
                        test_nxt      = 1'b0;
                        rstBusy_nxt   = RST_BUSY_CYC;
                        pwr_nxt       = (pwr_r == LCDCD_STANDBY) ? LCDCD_SLEEP : pwr_r;
                    end else if (!test_r) begin
                        if (cb[7:4] == 4'hF) begin
                            test_nxt = 1'b1;
                        end else if (cb[7:6] == 2'b01) begin
                            startLine_nxt = cb[5:0];
                        end else if (cb[7:4] == 4'hB) begin
                            page_nxt = cb[3:0];
                        end else if (cb[7:4] == 4'h1) begin
                            col_nxt = {cb[2:0], col_r[3:0]};
                        end else if (cb[7:4] == 4'h0) begin
                            col_nxt = {col_r[6:4], cb[3:0]};
                        end else if (cb[7:3] == 5'b00101) begin
                            pwrEn_nxt = cb[2:0];
                        end else if (cb[7:3] == 5'b00100) begin
                            ratio_nxt = cb[2:0];
                        end else if (cb[7:4] == 4'hC) begin
                            comRev_nxt = cb[3];
                        end else begin
                            case (cb)
                                CMD_DISP_OFF: dispOn_nxt = 1'b0;
                                CMD_DISP_ON: begin
                                    dispOn_nxt = 1'b1;
                                    pwr_nxt    = LCDCD_RUN;
                                end
                                CMD_SEG_NORM: segRev_nxt = 1'b0;
                                CMD_SEG_REV:  segRev_nxt = 1'b1;
                                CMD_BIAS6:    bias_nxt   = 1'b0;
                                CMD_BIAS5:    bias_nxt   = 1'b1;
                                CMD_INV_NORM: invert_nxt = 1'b0;
                                CMD_INV_REV:  invert_nxt = 1'b1;
                                CMD_ALL_NORM: begin
                                    allOn_nxt = 1'b0;
                                    pwr_nxt   = LCDCD_RUN;
                                end
                                CMD_ALL_ON: begin
                                    allOn_nxt = 1'b1;
                                    if (!dispOn_r) begin
                                        pwr_nxt = (indMode_r == 2'h0) ?
                                            LCDCD_SLEEP : LCDCD_STANDBY;
                                    end
                                end
                                CMD_IND_OFF: indMode_nxt = 2'h0;
                                CMD_IND_ON:  mode_nxt = LCDCD_INDWAIT;
                                CMD_VOL_MODE: mode_nxt = LCDCD_VOLWAIT;
                                CMD_RMW: begin
                                    rmw_nxt    = 1'b1;
                                    rmwCol_nxt = col_r;
                                end
                                CMD_END: begin
                                    col_nxt = rmw_r ? rmwCol_r : col_r;
                                    rmw_nxt = 1'b0;
                                end
                                default: ;
                            endcase
                        end
                    end
                end
            endcase
        end

        // display ram stays reachable in power save
        if (dataWr) begin
            ramWe   = 1'b1;
            col_nxt = colInc(col_r);
        end
        if (dataRd) begin
            rdata_nxt = {24'h0, dispRam_r[pageIdx(page_r)][col_r]};
            col_nxt   = rmw_r ? col_r : colInc(col_r);
        end
        if (cmdRd) begin
            rdata_nxt = {24'h0, rstBusy_r != 2'h0, segRev_r, !dispOn_r,
                         rstBusy_r != 2'h0, 4'h0};
        end
        if (read && !ack_r && address == OFF_STATE) begin
            rdata_nxt = {12'h0, 2'(pwr_r), 2'(mode_r), indMode_r, test_r, rmw_r,
                         ratio_r, pwrEn_r, comRev_r, bias_r, invert_r, allOn_r,
                         dispOn_r, segRev_r};
        end
        if (read && !ack_r && address == OFF_STATE2) begin
            rdata_nxt = {3'h0, startLine_r, page_r, col_r, 6'h0, volume_r};
        end
    end

    // ======================================================
    // state registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_r       <= 1'b0;
            rdata_r     <= 32'h0;
            mode_r      <= LCDCD_NORMAL;
            pwr_r       <= LCDCD_RUN;
            dispOn_r    <= 1'b0;
            allOn_r     <= 1'b0;
            invert_r    <= 1'b0;
            startLine_r <= 6'h00;
            page_r      <= 4'h0;
            col_r       <= 7'h00;
            rmwCol_r    <= 7'h00;
            rmw_r       <= 1'b0;
            segRev_r    <= 1'b0;
            bias_r      <= 1'b0;
            comRev_r    <= 1'b0;
            pwrEn_r     <= 3'h0;
            ratio_r     <= RST_RATIO;
            volume_r    <= RST_VOLUME;
            indMode_r   <= 2'h0;
            test_r      <= 1'b0;
            rstBusy_r   <= 2'h0;
        end else begin
            ack_r       <= ack_nxt;
            rdata_r     <= rdata_nxt;
            mode_r      <= mode_nxt;
            pwr_r       <= pwr_nxt;
            dispOn_r    <= dispOn_nxt;
            allOn_r     <= allOn_nxt;
            invert_r    <= invert_nxt;
            startLine_r <= startLine_nxt;
            page_r      <= page_nxt;
            col_r       <= col_nxt;
            rmwCol_r    <= rmwCol_nxt;
            rmw_r       <= rmw_nxt;
            segRev_r    <= segRev_nxt;
            bias_r      <= bias_nxt;
            comRev_r    <= comRev_nxt;
            pwrEn_r     <= pwrEn_nxt;
            ratio_r     <= ratio_nxt;
            volume_r    <= volume_nxt;
            indMode_r   <= indMode_nxt;
            test_r      <= test_nxt;
            rstBusy_r   <= rstBusy_nxt;
        end
    end

    // display ram holds no reset, contents survive every reset
    always_ff @(posedge clk) begin
        if (ramWe) begin
            dispRam_r[ramPage][ramCol] <= cb;
        end
    end

    // ======================================================
    // registered outputs, derived from next state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            waitrequest         <= 1'b1;
            readdata            <= 32'h0;
            blank_out_n         <= 1'b1;
            indicator_drive_out <= 2'h0;
            lcd_drive_level     <= RST_VOLUME;
            oscEnable           <= 1'b1;
            driversEnable       <= 1'b1;
            segmentReverse      <= 1'b0;
            powerEnables        <= 3'h0;
            divider_ratio       <= RST_RATIO;
            biasFifth           <= 1'b0;
            comReverse          <= 1'b0;
            testMode            <= 1'b0;
        end else begin
            waitrequest         <= !ack_nxt;
            readdata            <= rdata_nxt;
            blank_out_n         <= pwr_nxt == LCDCD_RUN;
            // standby keeps the static indicator running, sleep stops it
            indicator_drive_out <= (pwr_nxt == LCDCD_SLEEP) ? 2'h0 : indMode_nxt;
            lcd_drive_level     <= volume_nxt;
            oscEnable           <= pwr_nxt != LCDCD_SLEEP;
            driversEnable       <= pwr_nxt == LCDCD_RUN;
            segmentReverse      <= segRev_nxt;
            // supply circuits halted in either save mode, settings kept
            powerEnables        <= (pwr_nxt == LCDCD_RUN) ? pwrEn_nxt : 3'h0;
            divider_ratio       <= ratio_nxt;
            biasFifth           <= bias_nxt;
            comReverse          <= comRev_nxt;
            testMode            <= test_nxt;
        end
    end

    // ======================================================
    // checks
    property p_volLoad;
        @(posedge clk) disable iff (!resetn)
        (cmdWr && mode_r == LCDCD_VOLWAIT) |=> (mode_r == LCDCD_NORMAL)
            && volume_r == $past(writedata[5:0]);
    endproperty
    a_volLoad: assert property (p_volLoad) else $error("volume load failed");
    property p_indLoad;
        @(posedge clk) disable iff (!resetn)
        (cmdWr && mode_r == LCDCD_INDWAIT) |=> indMode_r == $past(writedata[1:0]);
    endproperty
    a_indLoad: assert property (p_indLoad) else $error("indicator load failed");
    property p_saveEnter;
        @(posedge clk) disable iff (!resetn)
        (cmdWr && mode_r == LCDCD_NORMAL && !test_r && cb == CMD_ALL_ON && !dispOn_r)
            |=> pwr_r == ((indMode_r == 2'h0) ? LCDCD_SLEEP : LCDCD_STANDBY);
    endproperty
    a_saveEnter: assert property (p_saveEnter) else $error("power save entry wrong");
    property p_blank;
        @(posedge clk) disable iff (!resetn)
        blank_out_n == (pwr_r == LCDCD_RUN);
    endproperty
    a_blank: assert property (p_blank) else $error("blank output not low");
    property p_standbyReset;
        @(posedge clk) disable iff (!resetn)
        (cmdWr && mode_r == LCDCD_NORMAL && cb == CMD_RESET && pwr_r == LCDCD_STANDBY)
            |=> pwr_r == LCDCD_SLEEP ##1 !oscEnable;
    endproperty
    a_standbyReset: assert property (p_standbyReset) else $error("standby reset");
    property p_testEntry;
        @(posedge clk) disable iff (!resetn)
        (cmdWr && mode_r == LCDCD_NORMAL && cb[7:4] == 4'hF) |=> ##1 testMode;
    endproperty
    a_testEntry: assert property (p_testEntry) else $error("test entry missed");
    property p_rmwRead;
        @(posedge clk) disable iff (!resetn)
        (dataRd && rmw_r && !cmdWr) |=> $stable(col_r);
    endproperty
    a_rmwRead: assert property (p_rmwRead) else $error("rmw read moved column");
    property p_statusLow;
        @(posedge clk) disable iff (!resetn)
        cmdRd |=> readdata[3:0] == 4'h0 && readdata[6] == segRev_r;
    endproperty
    a_statusLow: assert property (p_statusLow) else $error("status byte wrong");
    property p_wait;
        @(posedge clk) disable iff (!resetn)
        ($rose(read) || $rose(write)) && waitrequest |-> ##1 !waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("no answer in one cycle");
endmodule

`default_nettype wire

//--- bench/lcdcd_host.sv
// Purpose: host model, avalon-mm master for the decoder
// Assumes: one clock; the answer is waitrequest seen low
// Notes:   hang rises if an answer never comes
`timescale 1ns/1ps
`default_nettype none
module lcdcd_host (
    // clock
    input  wire logic        clk,
    // avalon-mm master
    output logic [3:0]       address,
    output logic             read,
    output logic             write,
    output logic [31:0]      writedata,
    output logic [3:0]       byteenable,
    input  wire logic [31:0] readdata,
    input  wire logic        waitrequest,
    output logic             hang
);
    // ====================
    // idle bus from time zero
    initial begin
        {address, read, write, writedata, hang} = '0;
        byteenable = 4'hF;
    end
    // request held until waitrequest is sampled low, then released
    task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
                        output logic [31:0] q);
        int n;
        @(posedge clk);
        address <= a;
        writedata <= {24'h0, d};
        {write, read} <= {w, ~w};
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (waitrequest === 1'h0) break;
        end
        q = readdata;
        hang <= (n == 100);
        {write, read} <= 2'h0;
    endtask
endmodule
`default_nettype wire

//--- bench/test_lcd_command_decoder.sv
// Purpose: self-checking bench for the lcd command decoder
// Assumes: host model runs one transfer at a time
// Notes:   state words give many fields per read
`timescale 1ns/1ps
`default_nettype none
module test_lcd_command_decoder;
    import lcdcd_pkg::*;
    // ====================
    logic        clk = 1'h0;
    logic        resetn = 1'h0;
    logic        read, write, waitrequest, hang, blank_out_n, oscEnable;
    logic        driversEnable, segmentReverse, biasFifth, comReverse, testMode;
    logic [1:0]  indicator_drive_out;
    logic [2:0]  powerEnables, divider_ratio;
    logic [3:0]  address, byteenable;
    logic [5:0]  lcd_drive_level;
    logic [31:0] writedata, readdata, rdv, prev, junk;
    int          err_total = 0;
    int          cmp_count = 0;
    // command, field shift, mask, expected field of the state word
    logic [31:0] tbl [21] = '{32'hAF010101, 32'hA1000101, 32'hA0000100, 32'hA3040101,
        32'hA2040100, 32'hC8050101, 32'hC3050100, 32'hCF050101, 32'h2F060707, 32'h2A060702,
        32'h27090707, 32'hA7030101, 32'hA5020101, 32'hA4020100, 32'hA6030100, 32'hA1000101,
        32'hF50D0101, 32'hA0000101, 32'hE30D0100, 32'hF00D0101, 32'hE20D0100};
    always #4 clk = ~clk;
    lcdcd_decoder dut_u (.clk(clk), .resetn(resetn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .blank_out_n(blank_out_n), .testMode(testMode),
        .indicator_drive_out(indicator_drive_out), .lcd_drive_level(lcd_drive_level),
        .oscEnable(oscEnable), .driversEnable(driversEnable), .biasFifth(biasFifth),
        .segmentReverse(segmentReverse), .powerEnables(powerEnables),
        .divider_ratio(divider_ratio), .comReverse(comReverse));
    lcdcd_host host_u (.clk(clk), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .hang(hang));
    // ====================
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic cmds(input logic [7:0] q[$]);
        foreach (q[i]) host_u.xfer(1'h1, OFF_CMD, q[i], junk);
    endtask
    task automatic rd(input logic [3:0] a);
        host_u.xfer(1'h0, a, 8'h00, rdv);
    endtask
    // a stuck transfer would hang the run, so it ends it
    always @(posedge hang) begin
        err_total++;
        test_done();
    end
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'h1;
        chk("rst", {blank_out_n, oscEnable, lcd_drive_level}, {2'h3, RST_VOLUME});
        cmds('{CMD_VOL_MODE, 8'h3F, CMD_SEG_REV});
        chk("vol", {lcd_drive_level, segmentReverse}, {6'h3F, 1'h1});
        cmds('{CMD_VOL_MODE, CMD_BIAS5});
        chk("vol", {lcd_drive_level, biasFifth}, {6'h23, 1'h0});
        for (int m = 0; m < 4; m++) begin
            cmds('{CMD_IND_ON, 8'(m)});
            chk("ind", indicator_drive_out, m[1:0]);
        end
        cmds('{CMD_DISP_ON, CMD_INV_REV, CMD_DISP_OFF});
        chk("ind", indicator_drive_out, 2'h3);
        foreach (tbl[i]) begin
            cmds('{tbl[i][31:24]});
            rd(OFF_STATE);
            chk("state", (rdv >> tbl[i][23:16]) & tbl[i][15:8], tbl[i][7:0]);
        end
        chk("rst", {lcd_drive_level, divider_ratio, comReverse, indicator_drive_out},
            {RST_VOLUME, RST_RATIO, 3'h0});
        chk("run", {testMode, powerEnables}, 4'h2);
        prev = rdv;
        cmds('{8'h90});
        rd(OFF_STATE);
        chk("undef", rdv, prev);
        rd(4'h2);
        chk("unmapped", rdv, prev);
        cmds('{CMD_IND_ON, 8'h03, CMD_IND_OFF, CMD_SEG_NORM});
        chk("ind", {indicator_drive_out, segmentReverse}, 3'h0);
        $display("test decode done");
        cmds('{CMD_DISP_OFF, CMD_ALL_ON});
        chk("sleep", {blank_out_n, oscEnable, driversEnable, powerEnables}, 6'h0);
        rd(OFF_CMD);
        chk("status", rdv, 32'h20);
        cmds('{CMD_ALL_NORM, CMD_IND_ON, 8'h01, CMD_ALL_ON});
        chk("standby", {blank_out_n, oscEnable, driversEnable}, 3'h2);
        cmds('{CMD_RESET});
        chk("sleep", oscEnable, 1'h0);
        cmds('{8'h6A, 8'hB2, 8'h11, 8'h03});
        host_u.xfer(1'h1, OFF_DATA, 8'h5A, junk);
        cmds('{8'h11, 8'h03, CMD_RMW});
        rd(OFF_DATA);
        chk("data", rdv[7:0], 8'h5A);
        rd(OFF_STATE2);
        chk("addr", (rdv >> 12) & 32'h1FFFF, {6'h2A, 4'h2, 7'h13});
        host_u.xfer(1'h1, OFF_DATA, 8'hC3, junk);
        rd(OFF_STATE2);
        chk("col", rdv[18:12], 7'h14);
        cmds('{CMD_END});
        rd(OFF_STATE2);
        chk("end", rdv[18:12], 7'h13);
        $display("test data done");
        test_done();
    end
endmodule
`default_nettype wire
